// *** rtl/amd_decoder.sv ***
// addressing mode decoder and operand sequencer of the small cpu
`timescale 1ns/1ps

// Overview of operation
// RQ1: eight addressing modes are decoded from the opcode high nibble.
// RQ2: inherent opcodes are one byte and put out no operand address.
// RQ3: immediate opcodes are two bytes and the second byte is the operand itself.
// RQ4: direct opcodes are two bytes with the second byte as address low and zero high.
// RQ5: bit test and branch is three bytes, direct operand then relative target.
// RQ6: extended opcodes are three bytes, high address byte first then low.
// RQ7: indexed without offset is one byte, address is index with zero high byte.
// RQ8: indexed 8-bit offset is two bytes, address is index plus offset with carry to bit 8.
// RQ9: indexed 16-bit offset is three bytes, address is index plus high-first 16-bit offset.
// RQ10: a taken branch adds the sign-extended offset to the pc past the branch, else falls on.
// RQ11: register/memory opcodes fetch one operand from memory for the accumulator or index; stores write the result there instead.
// RQ12: read-modify-write reads, modifies and writes back the same place, except test never writes.
// RQ13: single-bit set and clear on memory are done as read-modify-write.
// RQ14: bit test and branch copies the tested bit into carry whether or not it branches.
module amd_decoder (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic [7:0] i_rdata,
  input wire logic i_cond,
  input wire logic [7:0] i_result,
  input wire logic i_reg_write,
  input wire amd_pkg::amd_regs_s i_reg_load,
  output amd_pkg::amd_bus_s o_bus,
  output amd_pkg::amd_regs_s o_regs,
  output amd_pkg::amd_decode_s o_decode,
  output logic [7:0] o_opcode,
  output logic [7:0] o_operand,
  output logic o_operand_valid,
  output logic o_carry,
  output logic o_carry_write,
  output logic o_branch_taken,
  output logic o_busy,
  output logic o_done
);
  import amd_pkg::*;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic amd_decode_s decode_op(input logic [7:0] op);
    amd_decode_s d;
    logic [3:0] hi;
    hi = op[AMD_HI_NIBBLE_LSB +: 4];
    d = '{mode: AMD_INH, kind: AMD_K_CTRL, length: 2'd1};
    case (hi)
      AMD_ROW_BIT: begin
        d = '{mode: AMD_DIR, kind: AMD_K_BITBR, length: 2'd3}; // see RQ5
      end
      AMD_ROW_SET_MEMORY_BIT: begin
        d = '{mode: AMD_DIR, kind: AMD_K_BITSET, length: 2'd2}; // see RQ13
      end
      AMD_ROW_BRANCH: begin
        d = '{mode: AMD_REL, kind: AMD_K_BRANCH, length: 2'd2}; // see RQ10
      end
      AMD_ROW_RMW_DIR: begin
        d = '{mode: AMD_DIR, kind: AMD_K_RMW, length: 2'd2};
      end
      AMD_ROW_RMW_A, AMD_ROW_RMW_X: begin
        d = '{mode: AMD_INH, kind: AMD_K_RMW, length: 2'd1}; // see RQ2
      end
      AMD_ROW_RMW_IX1: begin
        d = '{mode: AMD_IX1, kind: AMD_K_RMW, length: 2'd2};
      end
      AMD_ROW_RMW_IX0: begin
        d = '{mode: AMD_IX0, kind: AMD_K_RMW, length: 2'd1};
      end
      AMD_ROW_IMM: begin
        d = '{mode: AMD_IMM, kind: AMD_K_REGMEM, length: 2'd2}; // see RQ3
      end
      AMD_ROW_DIR: begin
        d = '{mode: AMD_DIR, kind: AMD_K_REGMEM, length: 2'd2}; // see RQ4
      end
      AMD_ROW_EXT: begin
        d = '{mode: AMD_EXT, kind: AMD_K_REGMEM, length: 2'd3}; // see RQ6
      end
      AMD_ROW_IX2: begin
        d = '{mode: AMD_IX2, kind: AMD_K_REGMEM, length: 2'd3}; // see RQ9
      end
      AMD_ROW_IX1: begin
        d = '{mode: AMD_IX1, kind: AMD_K_REGMEM, length: 2'd2}; // see RQ8
      end
      AMD_ROW_IX0: begin
        d = '{mode: AMD_IX0, kind: AMD_K_REGMEM, length: 2'd1}; // see RQ7
      end
      default: begin
        d = '{mode: AMD_INH, kind: AMD_K_CTRL, length: 2'd1}; // see RQ1
      end
    endcase
    // jumps carry an address but touch no operand
    if (hi >= AMD_ROW_DIR && (op[3:0] == AMD_COL_JMP || op[3:0] == AMD_COL_JSR)) begin
      d.kind = AMD_K_JUMP;
    end
    return d;
  endfunction

  function automatic logic [15:0] pc_plus(input logic [15:0] pc, input logic [15:0] inc);
    return 16'(pc + inc);
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    amd_state_e state;
    amd_decode_s dec;
    logic [7:0] opcode;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [15:0] ea;
    logic [7:0] operand;
    logic operand_valid;
    logic carry;
    logic carry_write;
    logic taken;
    logic done;
    logic second;
    amd_regs_s regs;
    amd_bus_s bus;
  } amd_state_s;

  amd_state_s s_q;
  amd_state_s s_d;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [15:0] ea;
    logic bit_val;
    logic is_store;
    ea = 16'h0000;
    bit_val = 1'b0;
    is_store = 1'b0;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.carry_write = 1'b0;
    s_d.operand_valid = 1'b0;
    s_d.bus.rd = 1'b0;
    s_d.bus.wr = 1'b0;
    // address formed every cycle, latched on the first READ cycle as the operand read, the store or the jump goes out
    case (s_q.dec.mode)
      AMD_DIR: ea = {AMD_ZERO_PAGE_HI, s_q.b1}; // see RQ4
      AMD_EXT: ea = {s_q.b1, s_q.b2}; // see RQ6
      AMD_IX0: ea = {AMD_ZERO_PAGE_HI, s_q.regs.idx}; // see RQ7
      AMD_IX1: ea = {7'h00, 9'({1'b0, s_q.regs.idx} + {1'b0, s_q.b1})}; // see RQ8
      AMD_IX2: ea = 16'({s_q.b1, s_q.b2} + {8'h00, s_q.regs.idx}); // see RQ9
      default: ea = 16'h0000;
    endcase
    // stores skip the read and put the result straight on the bus
    is_store = (s_q.dec.kind == AMD_K_REGMEM)
      && (s_q.opcode[3:0] == AMD_COL_STA || s_q.opcode[3:0] == AMD_COL_STX);
    // bit number sits in opcode bits 3..1, bit 0 picks the sense
    bit_val = i_rdata[s_q.opcode[AMD_BIT_SEL_LSB +: 3]];
    case (s_q.state)
      AMD_S_OPC: begin
        // register loads win over a start in the same cycle
        if (i_reg_write) begin
          s_d.regs = i_reg_load;
        end else if (i_start) begin
          s_d.bus.addr = s_q.regs.pc;
          s_d.bus.rd = 1'b1;
          s_d.regs.pc = pc_plus(s_q.regs.pc, 16'h0001);
          s_d.state = AMD_S_B1;
          s_d.opcode = i_rdata;
          // a new instruction forgets the last branch outcome
          s_d.taken = 1'b0;
        end
      end
      AMD_S_B1: begin
        // opcode byte is read back the cycle after its fetch
        if (s_q.bus.rd && s_q.bus.addr == pc_plus(s_q.regs.pc, 16'hFFFF)
            && s_q.dec.length == 2'd0) begin
          s_d.opcode = i_rdata;
        end
        s_d.opcode = i_rdata;
        s_d.dec = decode_op(i_rdata);
        if (decode_op(i_rdata).length == 2'd1) begin
          s_d.state = (decode_op(i_rdata).mode == AMD_INH) ? AMD_S_DONE : AMD_S_READ;
          if (decode_op(i_rdata).mode == AMD_INH && decode_op(i_rdata).kind == AMD_K_RMW) begin
            s_d.operand = (i_rdata[AMD_HI_NIBBLE_LSB +: 4] == AMD_ROW_RMW_A) ?
              s_q.regs.acc : s_q.regs.idx; // see RQ12
            s_d.operand_valid = 1'b1;
          end
        end else begin
          s_d.bus.addr = s_q.regs.pc;
          s_d.bus.rd = 1'b1;
          s_d.regs.pc = pc_plus(s_q.regs.pc, 16'h0001);
          s_d.state = AMD_S_B2;
        end
      end
      AMD_S_B2: begin
        // both operand bytes pass here; the flag marks the second fetch
        if (!s_q.second) begin
          s_d.b1 = i_rdata;
          if (s_q.dec.length == 2'd3) begin
            s_d.bus.addr = s_q.regs.pc;
            s_d.bus.rd = 1'b1;
            s_d.regs.pc = pc_plus(s_q.regs.pc, 16'h0001);
            s_d.second = 1'b1;
          end else if (s_q.dec.mode == AMD_IMM) begin
            s_d.operand = i_rdata; // see RQ3
            s_d.operand_valid = 1'b1;
            s_d.state = AMD_S_DONE;
          end else if (s_q.dec.mode == AMD_REL) begin
            s_d.taken = i_cond;
            if (i_cond) begin
              s_d.regs.pc = pc_plus(s_q.regs.pc, {{8{i_rdata[7]}}, i_rdata}); // see RQ10
            end
            s_d.state = AMD_S_DONE;
          end else begin
            s_d.state = AMD_S_READ;
          end
        end else begin
          s_d.b2 = i_rdata;
          s_d.second = 1'b0;
          s_d.state = AMD_S_READ;
        end
      end
      AMD_S_READ: begin
        if (!s_q.bus.rd) begin
          s_d.ea = ea;
          if (s_q.dec.kind == AMD_K_JUMP) begin
            s_d.regs.pc = ea;
            s_d.state = AMD_S_DONE;
          end else if (is_store) begin
            s_d.bus = '{addr: ea, rd: 1'b0, wr: 1'b1, wdata: i_result}; // see RQ11
            s_d.state = AMD_S_DONE;
          end else begin
            s_d.bus.addr = ea;
            s_d.bus.rd = 1'b1; // see RQ11
          end
        end else begin
          // memory answers in the cycle its read strobe stands
          s_d.operand = i_rdata;
          s_d.operand_valid = 1'b1;
          s_d.state = AMD_S_DONE;
          if (s_q.dec.kind == AMD_K_BITBR) begin
            s_d.carry = bit_val; // see RQ14
            s_d.carry_write = 1'b1;
            s_d.taken = (bit_val == ~s_q.opcode[0]);
            if (bit_val == ~s_q.opcode[0]) begin
              s_d.regs.pc = pc_plus(s_q.regs.pc, {{8{s_q.b2[7]}}, s_q.b2}); // see RQ5
            end
          end else if ((s_q.dec.kind == AMD_K_RMW && s_q.opcode[3:0] != AMD_COL_TST)
                       || s_q.dec.kind == AMD_K_BITSET) begin
            s_d.state = AMD_S_WRITE; // see RQ12
          end
        end
      end
      AMD_S_WRITE: begin
        // alu result is sampled in the same cycle the operand is shown
        s_d.bus = '{addr: s_q.ea, rd: 1'b0, wr: 1'b1, wdata: i_result}; // see RQ13
        s_d.state = AMD_S_DONE;
      end
      AMD_S_DONE: begin
        // inherent read-modify-write lands in the register, never in memory
        if (s_q.dec.kind == AMD_K_RMW && s_q.dec.mode == AMD_INH
            && s_q.opcode[3:0] != AMD_COL_TST) begin
          if (s_q.opcode[AMD_HI_NIBBLE_LSB +: 4] == AMD_ROW_RMW_A) begin
            s_d.regs.acc = i_result; // see RQ12
          end else begin
            s_d.regs.idx = i_result;
          end
        end
        s_d.taken = s_q.taken;
        s_d.done = 1'b1;
        s_d.state = AMD_S_OPC;
      end
      default: begin
        s_d.state = AMD_S_OPC;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.regs.pc <= AMD_RESET_PC;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_bus = s_q.bus;
  assign o_regs = s_q.regs;
  assign o_decode = s_q.dec;
  assign o_opcode = s_q.opcode;
  assign o_operand = s_q.operand;
  assign o_operand_valid = s_q.operand_valid;
  assign o_carry = s_q.carry;
  assign o_carry_write = s_q.carry_write;
  assign o_branch_taken = s_q.taken;
  assign o_busy = (s_q.state != AMD_S_OPC);
  assign o_done = s_q.done;

endmodule // amd_decoder

// *** include/amd_pkg.sv ***
// package for the addressing mode decoder: modes, opcode fields, bus and register carriers
package amd_pkg;

  // ****************************************
  // modes and kinds
  // ****************************************
  typedef enum logic [2:0] {
    AMD_INH = 3'b000,
    AMD_IMM = 3'b001,
    AMD_DIR = 3'b010,
    AMD_EXT = 3'b011,
    AMD_IX0 = 3'b100,
    AMD_IX1 = 3'b101,
    AMD_IX2 = 3'b110,
    AMD_REL = 3'b111
  } amd_mode_e;

  typedef enum logic [2:0] {
    AMD_K_CTRL = 3'b000,
    AMD_K_REGMEM = 3'b001,
    AMD_K_RMW = 3'b010,
    AMD_K_BRANCH = 3'b011,
    AMD_K_BITBR = 3'b100,
    AMD_K_BITSET = 3'b101,
    AMD_K_JUMP = 3'b110
  } amd_kind_e;

  typedef enum logic [3:0] {
    AMD_S_OPC = 4'h0,
    AMD_S_B1 = 4'h1,
    AMD_S_B2 = 4'h2,
    AMD_S_READ = 4'h3,
    AMD_S_WRITE = 4'h4,
    AMD_S_DONE = 4'h5
  } amd_state_e;

  // ****************************************
  // constants
  // ****************************************
  localparam logic [7:0] AMD_ZERO_PAGE_HI = 8'h00;
  localparam logic [15:0] AMD_RESET_PC = 16'h0000;
  localparam int AMD_HI_NIBBLE_LSB = 4;
  localparam int AMD_LO_NIBBLE_LSB = 0;
  localparam int AMD_BIT_SEL_LSB = 1;
  localparam logic [3:0] AMD_ROW_BIT = 4'h0;
  localparam logic [3:0] AMD_ROW_SET_MEMORY_BIT = 4'h1;
  localparam logic [3:0] AMD_ROW_BRANCH = 4'h2;
  localparam logic [3:0] AMD_ROW_RMW_DIR = 4'h3;
  localparam logic [3:0] AMD_ROW_RMW_A = 4'h4;
  localparam logic [3:0] AMD_ROW_RMW_X = 4'h5;
  localparam logic [3:0] AMD_ROW_RMW_IX1 = 4'h6;
  localparam logic [3:0] AMD_ROW_RMW_IX0 = 4'h7;
  localparam logic [3:0] AMD_ROW_IMM = 4'hA;
  localparam logic [3:0] AMD_ROW_DIR = 4'hB;
  localparam logic [3:0] AMD_ROW_EXT = 4'hC;
  localparam logic [3:0] AMD_ROW_IX2 = 4'hD;
  localparam logic [3:0] AMD_ROW_IX1 = 4'hE;
  localparam logic [3:0] AMD_ROW_IX0 = 4'hF;
  localparam logic [3:0] AMD_COL_TST = 4'hD;
  localparam logic [3:0] AMD_COL_CLR = 4'hF;
  localparam logic [3:0] AMD_COL_STA = 4'h7;
  localparam logic [3:0] AMD_COL_STX = 4'hF;
  localparam logic [3:0] AMD_COL_JMP = 4'hC;
  localparam logic [3:0] AMD_COL_JSR = 4'hD;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } amd_bus_s;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idx;
    logic [15:0] pc;
  } amd_regs_s;

  typedef struct packed {
    amd_mode_e mode;
    amd_kind_e kind;
    logic [1:0] length;
  } amd_decode_s;

endpackage

// *** test/amd_decoder_sva.sv ***
// port assertions of the addressing mode decoder
`timescale 1ns/1ps
module amd_decoder_sva (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire amd_pkg::amd_bus_s o_bus,
  input wire amd_pkg::amd_decode_s o_decode,
  input wire logic [7:0] o_opcode,
  input wire logic o_carry_write,
  input wire logic o_done
);
  import amd_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // bytes per instruction as the mode and kind imply
  function automatic logic [1:0] len_of(amd_decode_s d);
    if (d.kind == AMD_K_BITBR) return 2'h3;
    if (d.mode == AMD_INH || d.mode == AMD_IX0) return 2'h1;
    if (d.mode == AMD_EXT || d.mode == AMD_IX2) return 2'h3;
    return 2'h2;
  endfunction
  logic [3:0] row;
  assign row = o_opcode[7:4];
  property p_len;
    o_done |-> o_decode.length == len_of(o_decode);
  endproperty
  a_len: assert property (p_len) else $error("length disagrees with mode");
  property p_inh;
    o_bus.wr |-> o_decode.mode != AMD_INH;
  endproperty
  a_inh: assert property (p_inh) else $error("inherent wrote memory");
  property p_dir;
    o_bus.wr && o_decode.mode == AMD_DIR |-> o_bus.addr[15:8] == AMD_ZERO_PAGE_HI;
  endproperty
  a_dir: assert property (p_dir) else $error("direct left page zero");
  property p_ix0;
    o_bus.wr && o_decode.mode == AMD_IX0 |-> o_bus.addr[15:8] == AMD_ZERO_PAGE_HI;
  endproperty
  a_ix0: assert property (p_ix0) else $error("indexed left page zero");
  property p_ix1;
    o_bus.wr && o_decode.mode == AMD_IX1 |-> o_bus.addr <= 16'h01FE;
  endproperty
  a_ix1: assert property (p_ix1) else $error("offset index out of reach");
  property p_tst;
    o_bus.wr && (row == 4'h3 || row == 4'h6 || row == 4'h7) |-> o_opcode[3:0] != AMD_COL_TST;
  endproperty
  a_tst: assert property (p_tst) else $error("test wrote back");
  property p_carry;
    o_carry_write |-> o_decode.kind == AMD_K_BITBR && !o_bus.wr;
  endproperty
  a_carry: assert property (p_carry) else $error("carry from a non bit branch");
  property p_done;
    o_done |=> !o_done;
  endproperty
  a_done: assert property (p_done) else $error("done longer than a cycle");
  c_carry: cover property (o_carry_write);
  c_write: cover property (o_bus.wr);
  c_ix2: cover property (o_done && o_decode.mode == AMD_IX2);
endmodule // amd_decoder_sva
bind amd_decoder amd_decoder_sva u_sva (.i_clock(i_clock), .i_resetn(i_resetn), .o_bus(o_bus),
  .o_decode(o_decode), .o_opcode(o_opcode), .o_carry_write(o_carry_write), .o_done(o_done));

// *** test/amd_mem_model.sv ***
// program and data memory answering the decoder bus
`timescale 1ns/1ps
module amd_mem_model (
  input wire logic i_clock,
  input wire amd_pkg::amd_bus_s i_bus,
  output logic [7:0] o_rdata
);
  import amd_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
    last_q = 8'h00;
  end
  // data stands while the read strobe does; an idle bus shows the inverse of the last byte
  assign o_rdata = i_bus.rd ? mem[i_bus.addr] : ~last_q;
  always @(posedge i_clock) begin
    if (i_bus.wr) mem[i_bus.addr] <= i_bus.wdata;
    if (i_bus.rd) last_q <= mem[i_bus.addr];
  end
endmodule // amd_mem_model

// *** test/amd_decoder_bench.sv ***
// self-checking bench of the addressing mode decoder
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module amd_decoder_bench;
  import amd_pkg::*;
  logic i_clock, i_resetn, i_start, i_cond, i_reg_write;
  logic [7:0] i_result, rdata, o_opcode, o_operand, wd;
  amd_regs_s i_reg_load, o_regs;
  amd_bus_s o_bus;
  amd_decode_s o_decode;
  logic o_operand_valid, o_carry, o_carry_write, o_branch_taken, o_busy, o_done;
  logic [15:0] wa;
  int nw = 0;
  int nv = 0;
  int mismatches = 0;
  int checked = 0;
  amd_decoder DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_start(i_start), .i_rdata(rdata),
    .i_cond(i_cond), .i_result(i_result), .i_reg_write(i_reg_write), .i_reg_load(i_reg_load),
    .o_bus(o_bus), .o_regs(o_regs), .o_decode(o_decode), .o_opcode(o_opcode),
    .o_operand(o_operand), .o_operand_valid(o_operand_valid), .o_carry(o_carry),
    .o_carry_write(o_carry_write), .o_branch_taken(o_branch_taken), .o_busy(o_busy),
    .o_done(o_done));
  amd_mem_model mem_u (.i_clock(i_clock), .i_bus(o_bus), .o_rdata(rdata));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (o_bus.wr === 1'b1) begin
    wa <= o_bus.addr;
    wd <= o_bus.wdata;
    nw <= nw + 1;
  end
  always @(posedge i_clock) if (o_operand_valid === 1'b1) nv <= nv + 1;
  // ****
  // one instruction at 0200 with index x
  // ****
  task automatic run(input logic [7:0] b0, b1, b2, x, input logic c);
    @(posedge i_clock);
    mem_u.mem[16'h0200] = b0;
    mem_u.mem[16'h0201] = b1;
    mem_u.mem[16'h0202] = b2;
    i_reg_load <= '{acc: 8'h11, idx: x, pc: 16'h0200};
    i_cond <= c;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
    i_start <= 1'b1;
    @(posedge i_clock);
    i_start <= 1'b0;
    @(negedge i_clock);
    `CHK(o_busy, 1'b1)
    for (int n = 0; n < 20 && o_done !== 1'b1; n++) @(negedge i_clock);
    `CHK(o_done, 1'b1)
  endtask
  task automatic t_modes();
    logic [7:0] op [6] = '{8'hA6, 8'hB6, 8'hC6, 8'hD6, 8'hE6, 8'hF6};
    logic [7:0] b1 [6] = '{8'h5A, 8'h80, 8'hAB, 8'h12, 8'hFF, 8'h00};
    logic [7:0] b2 [6] = '{8'h00, 8'h00, 8'hCD, 8'h34, 8'h00, 8'h00};
    logic [15:0] ea [6] = '{16'h0000, 16'h0080, 16'hABCD, 16'h1324, 16'h01EF, 16'h00F0};
    logic [1:0] ln [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1};
    amd_mode_e md [6] = '{AMD_IMM, AMD_DIR, AMD_EXT, AMD_IX2, AMD_IX1, AMD_IX0};
    int n0;
    for (int i = 0; i < 6; i++) begin
      n0 = nv;
      run(op[i], b1[i], b2[i], 8'hF0, 1'b0);
      `CHK(o_opcode, op[i])
      `CHK(nv, n0 + 1)
      `CHK(o_decode.mode, md[i])
      `CHK(o_decode.length, ln[i])
      `CHK(o_regs.pc, 16'h0200 + ln[i])
      `CHK(o_operand, (i == 0) ? b1[i] : ea[i][7:0] ^ ea[i][15:8])
    end
    $display("test modes done");
  endtask
  task automatic t_rmw();
    int n0;
    n0 = nw;
    @(posedge i_clock);
    i_result <= 8'h3C;
    run(8'h3C, 8'h40, 8'h00, 8'h00, 1'b0);
    `CHK(wa, 16'h0040)
    `CHK(wd, 8'h3C)
    run(8'h3D, 8'h40, 8'h00, 8'h00, 1'b0);
    `CHK(nw, n0 + 1)
    run(8'h12, 8'h41, 8'h00, 8'h00, 1'b0);
    `CHK(wa, 16'h0041)
    run(8'h6C, 8'hFF, 8'h00, 8'hF0, 1'b0);
    `CHK(wa, 16'h01EF)
    run(8'h7C, 8'h00, 8'h00, 8'hF0, 1'b0);
    `CHK(wa, 16'h00F0)
    run(8'h4C, 8'h00, 8'h00, 8'h00, 1'b0);
    `CHK(o_regs.acc, 8'h3C)
    `CHK(nw, n0 + 4)
    `CHK(o_regs.pc, 16'h0201)
    $display("test rmw done");
  endtask
  task automatic t_branch();
    logic [7:0] of [3] = '{8'h80, 8'h7F, 8'h7F};
    logic cd [3] = '{1'b1, 1'b1, 1'b0};
    logic [15:0] pc [3] = '{16'h0182, 16'h0281, 16'h0202};
    for (int i = 0; i < 3; i++) begin
      run(8'h20, of[i], 8'h00, 8'h00, cd[i]);
      `CHK(o_regs.pc, pc[i])
      `CHK(o_branch_taken, cd[i])
    end
    $display("test branch done");
  endtask
  task automatic t_bitbr();
    logic [7:0] op [3] = '{8'h00, 8'h00, 8'h01};
    logic [7:0] ad [3] = '{8'h50, 8'h51, 8'h51};
    logic [7:0] of [3] = '{8'h10, 8'h10, 8'hF0};
    logic cy [3] = '{1'b1, 1'b0, 1'b0};
    logic [15:0] pc [3] = '{16'h0213, 16'h0203, 16'h01F3};
    mem_u.mem[16'h0050] = 8'h01;
    mem_u.mem[16'h0051] = 8'hFE;
    for (int i = 0; i < 3; i++) begin
      run(op[i], ad[i], of[i], 8'h00, 1'b0);
      `CHK(o_regs.pc, pc[i])
      `CHK(o_carry, cy[i])
    end
    $display("test bit branch done");
  endtask
  task automatic t_jump_store();
    int n0;
    n0 = nw;
    @(posedge i_clock);
    i_result <= 8'h5A;
    run(8'hCC, 8'h12, 8'h34, 8'h00, 1'b0);
    `CHK(o_regs.pc, 16'h1234)
    run(8'hB7, 8'h60, 8'h00, 8'h00, 1'b0);
    `CHK(wa, 16'h0060)
    `CHK(wd, 8'h5A)
    `CHK(nw, n0 + 1)
    $display("test jump store done");
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    i_resetn = 1'b0;
    i_start = 1'b0;
    i_cond = 1'b0;
    i_reg_write = 1'b0;
    i_result = 8'h00;
    i_reg_load = '0;
    repeat (16) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(negedge i_clock);
    `CHK(o_regs, 32'h0)
    t_modes();
    t_rmw();
    t_branch();
    t_bitbr();
    t_jump_store();
    complete_run();
  end
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
endmodule // amd_decoder_bench
